// ### common/aipc_pkg.sv
`default_nettype none
package aipc_pkg;

  // Geometry
  localparam int NUM_PORTS = 4;
  localparam int NUM_CH    = 6;
  localparam int MANT_W    = 16;
  localparam int GAIN_W    = 3;
  localparam int CAL_W     = 4;
  localparam int SEL_W     = 3;

  // Port indices
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;

  // Pad control register
  localparam int            PAD_W           = 11;
  localparam int            PAD_MODE_BIT    = 10;
  localparam int            PAD_RSVD_BIT    = 9;
  localparam int            PAD_AUTOCAL_BIT = 8;
  localparam int            PAD_CAL_LSB     = 0;
  localparam logic [10:0]   PAD_RESET       = 11'h600;
  localparam logic [10:0]   PAD_RMASK       = 11'h70F;

  // Routing control register
  localparam int            ROUTE_W     = 28;
  localparam int            PN_EN_BIT   = 27;
  localparam int            PN_LOCK_BIT = 26;
  localparam int            PAIR_C_BIT  = 25;
  localparam int            PAIR_A_BIT  = 24;
  localparam int            CH_GRP_W    = 4;
  localparam logic [27:0]   ROUTE_RESET = 28'h0000000;

  // Crossbar codes, real mode
  localparam logic [2:0] SEL_R_A  = 3'h0;
  localparam logic [2:0] SEL_R_B  = 3'h1;
  localparam logic [2:0] SEL_R_C  = 3'h2;
  localparam logic [2:0] SEL_R_D  = 3'h3;
  localparam logic [2:0] SEL_R_PN = 3'h4;
  // Crossbar codes, complex mode
  localparam logic [2:0] SEL_C_AB = 3'h0;
  localparam logic [2:0] SEL_C_CD = 3'h1;
  localparam logic [2:0] SEL_C_PN = 3'h2;

  // Test pattern generator
  localparam int           PN_W      = 23;
  localparam int           PN_TAP_LO = 17;
  localparam logic [22:0]  PN_SEED   = 23'h5A5A5A;
  localparam logic [2:0]   GAIN_FULL = 3'h0;

  // Pad calibration timing
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          CAL_SETTLE_NS  = 200;
  localparam int          CAL_SETTLE_CYC =
    (CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CAL_WAIT_W     = 8;
  localparam logic [3:0]  CAL_MAX        = 4'hF;

  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic [MANT_W-1:0] mant;
  } aipc_smp_t;

  typedef struct packed {
    logic      cplx;
    aipc_smp_t i;
    aipc_smp_t q;
  } aipc_chan_t;

  typedef struct packed {
    logic             cplx;
    logic [SEL_W-1:0] sel;
  } aipc_chcfg_t;

endpackage
`default_nettype wire

// ### logic/aipc_pad_cal.sv
`timescale 1ns/1ps
`default_nettype none
module aipc_pad_cal (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Control
  input  wire logic                        autoCalEn,
  input  wire logic [aipc_pkg::CAL_W-1:0]  manualCal,
  // Pad comparator, asynchronous
  input  wire logic                        calSense,
  // Result
  output logic      [aipc_pkg::CAL_W-1:0]  calCode,
  output logic                             calBusy,
  output logic                             calDone
);

  typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_HOLD} aipc_cal_st_t;

  aipc_cal_st_t                         state_ff;
  logic                                 autoD_ff;
  logic [2:0]                           sense_ff;
  logic                                 senseLvl_ff;
  logic [aipc_pkg::CAL_W-1:0]           trial_ff;
  logic [aipc_pkg::CAL_WAIT_W-1:0]      wait_ff;
  logic [aipc_pkg::CAL_W-1:0]           code_ff;
  logic                                 done_ff;
  logic                                 stepEnd;
  logic                                 found;

  // Level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      sense_ff    <= 3'h0;
      senseLvl_ff <= 1'b0;
    end else begin
      sense_ff <= {sense_ff[1:0], calSense};
      if (sense_ff[1] == sense_ff[2]) begin
        senseLvl_ff <= sense_ff[2];
      end
    end
  end

  assign stepEnd = (state_ff == CAL_SETTLE) &&
    (wait_ff == aipc_pkg::CAL_WAIT_W'(aipc_pkg::CAL_SETTLE_CYC - 1));
  assign found   = senseLvl_ff || (trial_ff == aipc_pkg::CAL_MAX);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= CAL_IDLE;
      autoD_ff <= 1'b0;
      trial_ff <= '0;
      wait_ff  <= '0;
    end else begin
      autoD_ff <= autoCalEn;
      unique case (state_ff)
        CAL_IDLE: begin
          if (autoCalEn && !autoD_ff) begin
            state_ff <= CAL_SETTLE;
            trial_ff <= '0;
            wait_ff  <= '0;
          end
        end
        CAL_SETTLE: begin
          if (!autoCalEn) begin
            state_ff <= CAL_IDLE;
          end else if (stepEnd) begin
            wait_ff <= '0;
            if (found) begin
              state_ff <= CAL_HOLD;
            end else begin
              trial_ff <= trial_ff + 1'b1;
            end
          end else begin
            wait_ff <= wait_ff + 1'b1;
          end
        end
        CAL_HOLD: begin
          if (!autoCalEn) begin
            state_ff <= CAL_IDLE;
          end
        end
      endcase
    end
  end

  // Auto result applied only at end of cycle; manual value otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      code_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= stepEnd && found && autoCalEn;
      if (!autoCalEn) begin
        code_ff <= manualCal;
      end else if (stepEnd && found) begin
        code_ff <= trial_ff;
      end
    end
  end

  assign calCode = code_ff;
  assign calBusy = (state_ff == CAL_SETTLE);
  assign calDone = done_ff;

  a_cal_manual: assert property (@(posedge clk) disable iff (reset)
    !autoCalEn |=> calCode == $past(manualCal))
    else $error("manual calibration value not applied");

  a_cal_apply: assert property (@(posedge clk) disable iff (reset)
    calDone |-> calCode == trial_ff && !calBusy)
    else $error("calibration result not applied at completion");

  a_cal_hold: assert property (@(posedge clk) disable iff (reset)
    calBusy && $past(autoCalEn) && autoCalEn |=> calDone || $stable(calCode))
    else $error("calibration code moved during a cycle");

  c_cal_run: cover property (@(posedge clk) disable iff (reset)
    calBusy ##[1:200] calDone);

endmodule
`default_nettype wire

// ### logic/aipc_crossbar.sv
//Function
// - Pad mode bit one runs the ports single-ended, zero runs them differential.
// - After reset the pad mode bit reads one.
// - In differential mode two single-ended pins form one differential pair.
// - Auto-calibration runs a calibration cycle and applies its result at the end.
// - Without auto-calibration the four-bit manual value drives the pads, else it is ignored.
// - The test source runs while enabled; disabling stops it and reloads its seed.
// - With the test source on its gain field is zero when lock is set and random when lock is clear.
// - Port C pairing makes C in-phase and D quadrature, presented as the C source.
// - Port A pairing makes A in-phase and B quadrature, presented as the A source.
// - Pairing works only in single-ended mode and must not be chosen otherwise.
// - Real single-ended mode has four ports; A pairing drops B, C pairing drops D, differential mode leaves only A and C.
// - A channel's complex bit feeds it complex samples, clear feeds it real ones.
// - Real select codes pick A, B, C, D or the test source.
// - Complex select codes pick pair AB, pair CD or the complex test source.
// - Each of six channels has a four-bit group, complex bit over a three-bit select.
`timescale 1ns/1ps
`default_nettype none
module aipc_crossbar #(
  parameter int NUM_CH = aipc_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                                    clk,
  input  wire logic                                    reset,
  // Pad control register
  input  wire logic                                    padWe,
  input  wire logic [aipc_pkg::PAD_W-1:0]              padWdata,
  output logic      [aipc_pkg::PAD_W-1:0]              padRdata,
  // Routing control register
  input  wire logic                                    routeWe,
  input  wire logic [aipc_pkg::ROUTE_W-1:0]            routeWdata,
  output logic      [aipc_pkg::ROUTE_W-1:0]            routeRdata,
  // Converter pins, A at index 0
  input  wire aipc_pkg::aipc_smp_t [aipc_pkg::NUM_PORTS-1:0] pinData,
  // Pad control
  input  wire logic                                    calSense,
  output logic                                         padSingleEnded,
  output logic      [aipc_pkg::CAL_W-1:0]              padCalCode,
  output logic                                         calBusy,
  output logic      [1:0]                              pairError,
  // Channel samples
  output var aipc_pkg::aipc_chan_t [NUM_CH-1:0]        chanOut
);

  logic [aipc_pkg::PAD_W-1:0]               padCtrl_ff;
  logic [aipc_pkg::ROUTE_W-1:0]             routeCtrl_ff;
  aipc_pkg::aipc_smp_t [aipc_pkg::NUM_PORTS-1:0] held_ff;
  aipc_pkg::aipc_smp_t [aipc_pkg::NUM_PORTS-1:0] liveSmp;
  logic [aipc_pkg::NUM_PORTS-1:0]           portLive;
  logic [aipc_pkg::PN_W-1:0]                pnLfsr_ff;
  aipc_pkg::aipc_smp_t                      pnI_ff;
  aipc_pkg::aipc_smp_t                      pnQ_ff;
  aipc_pkg::aipc_chan_t [NUM_CH-1:0]        chan_ff;
  logic [1:0]                               pairErr_ff;
  logic                                     cmosMode;
  logic                                     pairA;
  logic                                     pairC;
  logic                                     pnEn;
  logic                                     pnLock;

  // Register file
  always_ff @(posedge clk) begin
    if (reset) begin
      padCtrl_ff <= aipc_pkg::PAD_RESET;
    end else if (padWe) begin
      padCtrl_ff <= padWdata & aipc_pkg::PAD_RMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      routeCtrl_ff <= aipc_pkg::ROUTE_RESET;
    end else if (routeWe) begin
      routeCtrl_ff <= routeWdata;
    end
  end

  // Reserved bit reads back as written; software keeps it at one
  assign padRdata   = padCtrl_ff;
  assign routeRdata = routeCtrl_ff;

  assign cmosMode = padCtrl_ff[aipc_pkg::PAD_MODE_BIT];
  assign pnEn     = routeCtrl_ff[aipc_pkg::PN_EN_BIT];
  assign pnLock   = routeCtrl_ff[aipc_pkg::PN_LOCK_BIT];
  // Pairing request is ignored in differential mode
  assign pairA = routeCtrl_ff[aipc_pkg::PAIR_A_BIT] && cmosMode;
  assign pairC = routeCtrl_ff[aipc_pkg::PAIR_C_BIT] && cmosMode;

  assign padSingleEnded = cmosMode;

  // Pad calibration
  aipc_pad_cal u_pad_cal (
    .clk       (clk),
    .reset     (reset),
    .autoCalEn (padCtrl_ff[aipc_pkg::PAD_AUTOCAL_BIT]),
    .manualCal (padCtrl_ff[aipc_pkg::PAD_CAL_LSB +: aipc_pkg::CAL_W]),
    .calSense  (calSense),
    .calCode   (padCalCode),
    .calBusy   (calBusy),
    .calDone   ()
  );

  // Pin capture: word taken once stages two and three agree
  generate
    for (genvar p = 0; p < aipc_pkg::NUM_PORTS; p++) begin : g_port
      aipc_pkg::aipc_smp_t s1_ff;
      aipc_pkg::aipc_smp_t s2_ff;
      aipc_pkg::aipc_smp_t s3_ff;
      always_ff @(posedge clk) begin
        if (reset) begin
          s1_ff      <= '0;
          s2_ff      <= '0;
          s3_ff      <= '0;
          held_ff[p] <= '0;
        end else begin
          s1_ff <= pinData[p];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            held_ff[p] <= s3_ff;
          end
        end
      end
    end
  endgenerate

  // Working ports; B and D pins are the negative legs when differential
  always_comb begin
    portLive         = '0;
    portLive[aipc_pkg::PORT_A] = 1'b1;
    portLive[aipc_pkg::PORT_C] = 1'b1;
    portLive[aipc_pkg::PORT_B] = cmosMode && !pairA;
    portLive[aipc_pkg::PORT_D] = cmosMode && !pairC;
    for (int p = 0; p < aipc_pkg::NUM_PORTS; p++) begin
      liveSmp[p] = portLive[p] ? held_ff[p] : '0;
    end
  end

  // Leg mismatch flags, only meaningful when differential
  always_ff @(posedge clk) begin
    if (reset) begin
      pairErr_ff <= 2'h0;
    end else if (cmosMode) begin
      pairErr_ff <= 2'h0;
    end else begin
      pairErr_ff[0] <= held_ff[aipc_pkg::PORT_A] !=
                       ~held_ff[aipc_pkg::PORT_B];
      pairErr_ff[1] <= held_ff[aipc_pkg::PORT_C] !=
                       ~held_ff[aipc_pkg::PORT_D];
    end
  end

  assign pairError = pairErr_ff;

  // Test source: LFSR stepped every clock while enabled
  always_ff @(posedge clk) begin
    if (reset || !pnEn) begin
      pnLfsr_ff <= aipc_pkg::PN_SEED;
    end else begin
      pnLfsr_ff <= {pnLfsr_ff[aipc_pkg::PN_W-2:0],
                    pnLfsr_ff[aipc_pkg::PN_W-1] ^
                    pnLfsr_ff[aipc_pkg::PN_TAP_LO]};
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !pnEn) begin
      pnI_ff <= '0;
      pnQ_ff <= '0;
    end else begin
      pnI_ff.mant <= pnLfsr_ff[15:0];
      pnQ_ff.mant <= pnLfsr_ff[22:7];
      // Lock gives full-scale test samples
      pnI_ff.gain <= pnLock ? aipc_pkg::GAIN_FULL
                            : pnLfsr_ff[18:16];
      pnQ_ff.gain <= pnLock ? aipc_pkg::GAIN_FULL
                            : pnLfsr_ff[6:4];
    end
  end

  // Crossbar, one registered stage per channel
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
      aipc_pkg::aipc_chcfg_t cfg;
      aipc_pkg::aipc_chan_t  nxt_chan;
      assign cfg = routeCtrl_ff[c*aipc_pkg::CH_GRP_W +: aipc_pkg::CH_GRP_W];
      always_comb begin
        nxt_chan      = '0;
        nxt_chan.cplx = cfg.cplx;
        if (!cfg.cplx) begin
          unique case (cfg.sel)
            aipc_pkg::SEL_R_A:  nxt_chan.i = liveSmp[aipc_pkg::PORT_A];
            aipc_pkg::SEL_R_B:  nxt_chan.i = liveSmp[aipc_pkg::PORT_B];
            aipc_pkg::SEL_R_C:  nxt_chan.i = liveSmp[aipc_pkg::PORT_C];
            aipc_pkg::SEL_R_D:  nxt_chan.i = liveSmp[aipc_pkg::PORT_D];
            aipc_pkg::SEL_R_PN: nxt_chan.i = pnI_ff;
            default:            nxt_chan.i = '0;
          endcase
        end else begin
          // Unpaired port gives no complex source
          unique case (cfg.sel)
            aipc_pkg::SEL_C_AB: begin
              if (pairA) begin
                nxt_chan.i = held_ff[aipc_pkg::PORT_A];
                nxt_chan.q = held_ff[aipc_pkg::PORT_B];
              end
            end
            aipc_pkg::SEL_C_CD: begin
              if (pairC) begin
                nxt_chan.i = held_ff[aipc_pkg::PORT_C];
                nxt_chan.q = held_ff[aipc_pkg::PORT_D];
              end
            end
            aipc_pkg::SEL_C_PN: begin
              nxt_chan.i = pnI_ff;
              nxt_chan.q = pnQ_ff;
            end
            default: begin
              nxt_chan.i = '0;
              nxt_chan.q = '0;
            end
          endcase
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          chan_ff[c] <= '0;
        end else begin
          chan_ff[c] <= nxt_chan;
        end
      end
    end
  endgenerate

  assign chanOut = chan_ff;

  a_pad_reset: assert property (@(posedge clk)
    reset |=> padSingleEnded && padRdata[aipc_pkg::PAD_MODE_BIT])
    else $error("pad mode not single-ended after reset");

  a_pad_mode: assert property (@(posedge clk) disable iff (reset)
    padWe |=> padSingleEnded == $past(padWdata[aipc_pkg::PAD_MODE_BIT]))
    else $error("pad mode output does not follow register");

  a_pn_seed: assert property (@(posedge clk) disable iff (reset)
    !pnEn |=> pnLfsr_ff == aipc_pkg::PN_SEED && pnI_ff == '0)
    else $error("test source not stopped and reseeded");

  a_pn_lock: assert property (@(posedge clk) disable iff (reset)
    pnEn && pnLock |=> pnI_ff.gain == aipc_pkg::GAIN_FULL &&
                       pnQ_ff.gain == aipc_pkg::GAIN_FULL)
    else $error("locked test gain field not zero");

  a_pair_gate: assert property (@(posedge clk) disable iff (reset)
    !cmosMode |-> !pairA && !pairC && !portLive[aipc_pkg::PORT_B])
    else $error("pairing or port B active in differential mode");

  a_real_route: assert property (@(posedge clk) disable iff (reset)
    routeCtrl_ff[3:0] == {1'b0, aipc_pkg::SEL_R_D} && !pairC && cmosMode
    |=> chanOut[0].i == $past(held_ff[aipc_pkg::PORT_D]))
    else $error("real select D not routed to channel 0");

  a_cplx_route: assert property (@(posedge clk) disable iff (reset)
    routeCtrl_ff[3:0] == {1'b1, aipc_pkg::SEL_C_AB} && pairA
    |=> chanOut[0].cplx && chanOut[0].q == $past(held_ff[aipc_pkg::PORT_B]))
    else $error("pair AB not routed to channel 0");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (reset)
    routeCtrl_ff[NUM_CH*aipc_pkg::CH_GRP_W-1] &&
    routeCtrl_ff[NUM_CH*aipc_pkg::CH_GRP_W-2]
    |=> chanOut[NUM_CH-1].i == '0 && chanOut[NUM_CH-1].q == '0)
    else $error("reserved select code did not give zero samples");

  a_cplx_flag: assert property (@(posedge clk) disable iff (reset)
    ##1 chanOut[2].cplx == $past(routeCtrl_ff[2*aipc_pkg::CH_GRP_W+3]))
    else $error("channel complex flag mismatch");

  c_diff_mode: cover property (@(posedge clk) disable iff (reset)
    !cmosMode ##1 pairError == 2'h0);

  c_pn_real: cover property (@(posedge clk) disable iff (reset)
    pnEn && !pnLock && routeCtrl_ff[3:0] == {1'b0, aipc_pkg::SEL_R_PN});

  c_pair_cd: cover property (@(posedge clk) disable iff (reset)
    pairC && routeCtrl_ff[7:4] == {1'b1, aipc_pkg::SEL_C_CD});

endmodule
`default_nettype wire

// ### bench/aipc_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module aipc_adc_model (
  // Pad state seen from the device
  input  wire logic                                       padSingleEnded,
  input  wire logic     [aipc_pkg::CAL_W-1:0]             padCalCode,
  input  wire logic     [aipc_pkg::CAL_W-1:0]             calTarget,
  // Converter words, A at index 0
  input  wire aipc_pkg::aipc_smp_t [aipc_pkg::NUM_PORTS-1:0] word,
  output var aipc_pkg::aipc_smp_t  [aipc_pkg::NUM_PORTS-1:0] pinData,
  output logic                                            calSense
);
  // Differential: B and D pins carry the inverted leg of A and C
  always_comb begin
    pinData = word;
    if (!padSingleEnded) begin
      pinData[1] = ~word[0];
      pinData[3] = ~word[2];
    end
  end

  // Comparator trips once the code reaches the pad's matching point
  assign calSense = (padCalCode >= calTarget);
endmodule
`default_nettype wire

// ### bench/test_aipc_crossbar.sv
`timescale 1ns/1ps
`default_nettype none
module test_aipc_crossbar;
  logic                                            clk;
  logic                                            reset;
  logic                                            padWe;
  logic                                            routeWe;
  logic [10:0]                                     padWdata;
  logic [10:0]                                     padRdata;
  logic [27:0]                                     routeWdata;
  logic [27:0]                                     routeRdata;
  aipc_pkg::aipc_smp_t [aipc_pkg::NUM_PORTS-1:0]   word;
  aipc_pkg::aipc_smp_t [aipc_pkg::NUM_PORTS-1:0]   pinData;
  logic                                            calSense;
  logic                                            padSingleEnded;
  logic [3:0]                                      padCalCode;
  logic [3:0]                                      calTarget;
  logic                                            calBusy;
  logic [1:0]                                      pairError;
  aipc_pkg::aipc_chan_t [aipc_pkg::NUM_CH-1:0]     chanOut;
  logic [31:0]                                     seed;
  int                                              nErrors;
  int                                              samplesChecked;

  aipc_crossbar u_dut (.clk, .reset, .padWe, .padWdata, .padRdata, .routeWe,
    .routeWdata, .routeRdata, .pinData, .calSense, .padSingleEnded,
    .padCalCode, .calBusy, .pairError, .chanOut);

  aipc_adc_model u_adc (.padSingleEnded, .padCalCode, .calTarget, .word,
    .pinData, .calSense);

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected channel sample; zero where the source is not available
  function automatic aipc_pkg::aipc_chan_t expCh(input logic [3:0] g,
      input logic se, input logic pa, input logic pc);
    aipc_pkg::aipc_chan_t r;
    r = '0;
    if (!g[3]) begin
      case (g[2:0])
        3'h0: r.i = word[0];
        3'h1: if (se && !pa) r.i = word[1];
        3'h2: r.i = word[2];
        3'h3: if (se && !pc) r.i = word[3];
        default: r.i = '0;
      endcase
    end else begin
      r.cplx = 1'h1;
      case (g[2:0])
        3'h0: if (se && pa) begin r.i = word[0]; r.q = word[1]; end
        3'h1: if (se && pc) begin r.i = word[2]; r.q = word[3]; end
        default: r.cplx = 1'h0;
      endcase
    end
    return r;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic giveVerdict();
    $display("checks=%0d errors=%0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wrPad(input logic [10:0] v);
    @(posedge clk);
    padWe <= 1'h1;
    padWdata <= v;
    @(posedge clk);
    padWe <= 1'h0;
  endtask

  task automatic wrRoute(input logic [27:0] v);
    @(posedge clk);
    routeWe <= 1'h1;
    routeWdata <= v;
    @(posedge clk);
    routeWe <= 1'h0;
  endtask

  // Bounded wait on the calibration busy flag
  task automatic waitBusy(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && calBusy !== lvl; i++) tick(1);
    if (calBusy !== lvl) begin
      nErrors++;
      giveVerdict();
    end
  endtask

  initial begin
    logic                 se;
    logic [27:0]          r;
    aipc_pkg::aipc_chan_t e;
    aipc_pkg::aipc_smp_t  first;
    aipc_pkg::aipc_smp_t  prev;
    int                   moved;
    logic                 anyGain;
    reset = 1'h1;
    padWe = 1'h0;
    routeWe = 1'h0;
    padWdata = '0;
    routeWdata = '0;
    word = '0;
    calTarget = 4'h9;
    seed = 32'h65C6;
    nErrors = 0;
    samplesChecked = 0;
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    tick(1);
    check(padRdata, 11'h600);
    check(padSingleEnded, 1'h1);
    check(routeRdata, 28'h0000000);
    wrPad(11'h603);
    tick(2);
    check(padCalCode, 4'h3);
    // Manual field 3 set with autocal must not reach the pads
    wrPad(11'h703);
    waitBusy(1'h1, 10);
    waitBusy(1'h0, 200);
    // Pads keep the manual code during the sweep, so it runs to the top code
    check(padCalCode, aipc_pkg::CAL_MAX);
    check(padRdata, 11'h703);
    wrPad(11'h60A);
    tick(2);
    check(padCalCode, 4'hA);
    // Random pad mode, pairing and per-channel routing
    for (int k = 0; k < 48; k++) begin
      se = rnd() > 32'h7FFFFFFF;
      r = rnd();
      r[27] = 1'h0;
      if (!se) r[25:24] = 2'h0;
      wrPad({se, 1'h1, 9'h000});
      wrRoute(r);
      @(posedge clk);
      for (int p = 0; p < 4; p++) word[p] <= rnd();
      tick(8);
      check(padSingleEnded, se);
      check(routeRdata, r);
      check(pairError, 2'h0);
      for (int c = 0; c < 6; c++) begin
        e = expCh(r[4*c+:4], se, r[24], r[25]);
        check(chanOut[c].i, e.i);
        if (r[4*c+3]) check(chanOut[c].q, e.q);
        check(chanOut[c].cplx, r[4*c+3]);
      end
    end
    // Test source, locked gain then free gain, then seed reload
    wrPad(11'h600);
    wrRoute(28'hC0000A4);
    tick(3);
    first = chanOut[0].i;
    moved = 0;
    repeat (8) begin
      prev = chanOut[0].i;
      tick(1);
      check(chanOut[0].i.gain, 3'h0);
      check(chanOut[1].i.gain, 3'h0);
      if (chanOut[0].i !== prev) moved++;
    end
    check(moved != 0, 1'h1);
    wrRoute(28'h80000A4);
    anyGain = 1'h0;
    repeat (8) begin
      tick(1);
      anyGain = anyGain | (chanOut[0].i.gain != 3'h0);
    end
    check(anyGain, 1'h1);
    wrRoute(28'h00000A4);
    tick(3);
    check(chanOut[0].i, 19'h00000);
    wrRoute(28'hC0000A4);
    tick(3);
    check(chanOut[0].i, first);
    giveVerdict();
  end
endmodule
`default_nettype wire
